// file: test/rpscc_far_model.sv
// Far-side model: processor pins (select, strap levels) and link sense.
// Assumes the bench calls its tasks; every change lands after a pclk edge.
`timescale 1ns/1ns
module rpscc_far_model
  import rpscc_pkg::*;
(
  input wire logic pclk,
  output logic [1:0] port_sel_lvl,
  output logic [1:0] host_side_cfg_a,
  output logic [1:0] host_side_cfg_b,
  output logic [1:0] conn_side_cfg_a,
  output logic [1:0] conn_side_cfg_b,
  output logic far_term_present,
  output logic rx_activity
);
  // Pins start driven low so no current is pushed into the switch
  initial begin
    port_sel_lvl = LVL_LOW;
    host_side_cfg_a = LVL_LOW;
    host_side_cfg_b = LVL_LOW;
    conn_side_cfg_a = LVL_LOW;
    conn_side_cfg_b = LVL_LOW;
    far_term_present = 1'b0;
    rx_activity = 1'b0;
  end

  // Select pin change, just after an edge
  task automatic set_sel(input logic [1:0] s);
    @(posedge pclk);
    port_sel_lvl <= s;
  endtask

  // All four strap levels at once
  task automatic set_cfg(input logic [1:0] ha, input logic [1:0] hb,
                         input logic [1:0] ca, input logic [1:0] cb);
    @(posedge pclk);
    host_side_cfg_a <= ha;
    host_side_cfg_b <= hb;
    conn_side_cfg_a <= ca;
    conn_side_cfg_b <= cb;
  endtask

  // Link partner termination and line activity
  task automatic set_link(input logic t, input logic a);
    @(posedge pclk);
    far_term_present <= t;
    rx_activity <= a;
  endtask
endmodule // rpscc_far_model

// file: test/tb.sv
// Self-checking bench for the redriver port-select controller.
// Assumes the far model drives pins; bench is the APB master.
`timescale 1ns/1ns
module tb
  import rpscc_pkg::*;
();
  localparam int SC = 4;
  localparam int IC = 16;
  // Expected settings, index = first pin level * 3 + second pin level
  localparam logic [2:0] H_DE [9] = '{DE_M3P9, DE_M3P5, DE_0DB, DE_0DB,
    DE_M3P9, DE_M3P5, DE_0DB, DE_0DB, DE_M5P3};
  localparam logic [8:0] H_OS = 9'h155;
  localparam logic [1:0] H_EQ [9] = '{EQ_3DB, EQ_3DB, EQ_3DB, EQ_3DB,
    EQ_0DB, EQ_0DB, EQ_0DB, EQ_0DB, EQ_6DB};
  localparam logic [2:0] C_DE [9] = '{DE_M5P3, DE_M3P9, DE_M3P5, DE_M5P1,
    DE_M3P9, DE_M3P5, DE_M5P3, DE_M5P1, DE_M5P3};
  localparam logic [8:0] C_OS = 9'h153;
  localparam logic [1:0] C_EQ [9] = '{EQ_0DB, EQ_0DB, EQ_0DB, EQ_0DB,
    EQ_6DB, EQ_6DB, EQ_6DB, EQ_6DB, EQ_9DB};
  localparam logic [1:0] LV [3] = '{LVL_LOW, LVL_OPEN, LVL_HIGH};

  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [AW-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] sel, ha, hb, ca, cb, heq, ceq;
  logic term, act, p1en, p2en, p1hz, p2hz, t_ind, t_det, sq_en, act_st;
  logic [2:0] hde, cde;
  logic hos, cos, err;
  int error_cnt, tests_run;

  rpscc_far_model far (.pclk(pclk), .port_sel_lvl(sel),
    .host_side_cfg_a(ha), .host_side_cfg_b(hb), .conn_side_cfg_a(ca),
    .conn_side_cfg_b(cb), .far_term_present(term), .rx_activity(act));

  rpscc_top #(.SETTLE_CYC(SC), .IDLE_CYC(IC)) uut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port_sel_lvl(sel), .host_side_cfg_a(ha),
    .host_side_cfg_b(hb), .conn_side_cfg_a(ca), .conn_side_cfg_b(cb),
    .far_term_present(term), .rx_activity(act), .port1_pairs_en(p1en),
    .port2_pairs_en(p2en), .port1_hiz(p1hz), .port2_hiz(p2hz),
    .term_ind(t_ind), .term_detect_en(t_det), .squelch_en(sq_en),
    .active_state(act_st), .host_launch_emphasis_level(hde),
    .host_output_swing(hos), .host_receive_boost(heq),
    .conn_launch_emphasis_level(cde), .conn_output_swing(cos),
    .conn_receive_boost(ceq));

  // Clock, 50 ns period
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // Verdict and end of run
  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // One comparison
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // APB transfer: setup, access held until pready is sampled high
  task automatic apb(input logic wr, input logic [AW-1:0] a,
                     input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      chk("pready", 1, pready);
      complete_run();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  // Wait for active_state to reach a level, bounded
  task automatic wait_act(input logic lvl, input int lim, output int n);
    n = 0;
    do begin
      @(posedge pclk);
      #1;
      n++;
    end while (act_st !== lvl && n < lim);
    chk("active_state", lvl, act_st);
    if (act_st !== lvl) begin
      complete_run();
    end
  endtask

  // Select codes: only HIGH picks port 1
  task automatic t_sel;
    logic [1:0] codes [4];
    logic one;
    codes = '{LVL_LOW, LVL_OPEN, LVL_HIGH, 2'h3};
    for (int i = 0; i < 4; i++) begin
      far.set_sel(codes[i]);
      repeat (SC + 4) @(posedge pclk);
      #1;
      one = (i == 2);
      chk("port1_pairs_en", one, p1en);
      chk("port2_pairs_en", !one, p2en);
      chk("port1_hiz", !one, p1hz);
      chk("port2_hiz", one, p2hz);
      apb(1'b0, A_STAT, 32'h0);
      chk("stat_sel", one, rd[1]);
    end
    far.set_sel(LVL_LOW);
    repeat (SC + 4) @(posedge pclk);
    $display("DONE t_sel");
  endtask

  // Outputs and registers for one table entry
  task automatic cfg_check(input int i);
    repeat (SC + 4) @(posedge pclk);
    #1;
    chk("host_de", H_DE[i], hde);
    chk("host_os", H_OS[i], hos);
    chk("host_eq", H_EQ[i], heq);
    chk("conn_de", C_DE[i], cde);
    chk("conn_os", C_OS[i], cos);
    chk("conn_eq", C_EQ[i], ceq);
    apb(1'b0, A_HCFG, 32'h0);
    chk("hcfg_reg", {26'h0, H_DE[i], H_OS[i], H_EQ[i]}, rd);
    apb(1'b0, A_CCFG, 32'h0);
    chk("ccfg_reg", {26'h0, C_DE[i], C_OS[i], C_EQ[i]}, rd);
  endtask

  // All nine strap pairs on both sides, then an unknown code
  task automatic t_cfg;
    for (int a = 0; a < 3; a++) begin
      for (int b = 0; b < 3; b++) begin
        far.set_cfg(LV[a], LV[b], LV[a], LV[b]);
        cfg_check(a * 3 + b);
      end
    end
    far.set_cfg(2'h3, 2'h3, 2'h3, 2'h3);
    cfg_check(4);
    $display("DONE t_cfg");
  endtask

  // Active entry, idle wait, power saving
  task automatic t_power;
    int n;
    far.set_link(1'b1, 1'b1);
    wait_act(1'b1, 8, n);
    chk("term_ind", 1, t_ind);
    chk("term_detect_en", 0, t_det);
    chk("port2_pairs_en", 1, p2en);
    far.set_link(1'b1, 1'b0);
    wait_act(1'b0, IC + 10, n);
    chk("idle_wait_ok", 1, (n >= IC) && (n <= IC + 4));
    chk("term_detect_en", 1, t_det);
    chk("squelch_en", 1, sq_en);
    chk("port2_pairs_en", 1, p2en);
    chk("term_ind", 1, t_ind);
    $display("DONE t_power");
  endtask

  // Redetect command, events, select change, unmapped address
  task automatic t_cmd;
    int n;
    far.set_link(1'b1, 1'b1);
    wait_act(1'b1, 8, n);
    far.set_link(1'b1, 1'b0);
    apb(1'b1, A_CTRL, 32'h1);
    #1;
    chk("redetect", 0, act_st);
    apb(1'b0, A_EVT, 32'h0);
    chk("evt", 32'h3, rd);
    apb(1'b1, A_EVT, 32'h3);
    apb(1'b0, A_EVT, 32'h0);
    chk("evt_clr", 32'h0, rd);
    far.set_link(1'b1, 1'b1);
    wait_act(1'b1, 8, n);
    far.set_sel(LVL_HIGH);
    wait_act(1'b0, SC + 8, n);
    apb(1'b0, 12'h0FC, 32'h0);
    chk("unmapped_err", 1, err);
    chk("unmapped_data", 0, rd);
    $display("DONE t_cmd");
  endtask

  // Hang guard
  initial begin
    repeat (100000) @(posedge pclk);
    chk("run_time", 0, 1);
    complete_run();
  end

  // Reset, then the scenarios
  initial begin
    error_cnt = 0;
    tests_run = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    repeat (2) @(posedge pclk);
    #1;
    chk("rst_port2_en", 1, p2en);
    chk("rst_port1_hiz", 1, p1hz);
    chk("rst_active", 0, act_st);
    chk("rst_detect_en", 1, t_det);
    @(posedge pclk);
    presetn <= 1'b1;
    t_sel();
    t_cfg();
    t_power();
    t_cmd();
    complete_run();
  end
endmodule // tb

// file: verilog/rpscc_idle_tmr.sv
// Idle interval timer: expires after the link stays idle long enough.
// Assumes run is a combinational level decoded in the pclk domain.
`timescale 1ns/1ns
module rpscc_idle_tmr
  import rpscc_pkg::*;
#(
  parameter int IDLE_CYC = IDLE_CYC_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  output logic expired_r
);

  logic [CNT_W-1:0] cnt_r;
  wire logic at_end = (cnt_r == CNT_W'(IDLE_CYC - 1));

  // Count idle cycles, restart whenever the link wakes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
      expired_r <= 1'b0;
    end else if (!run) begin
      cnt_r <= '0;
      expired_r <= 1'b0;
    end else if (at_end) begin
      expired_r <= 1'b1;
    end else begin
      cnt_r <= cnt_r + CNT_W'(1);
    end
  end

  idle_wait_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(expired_r) |-> $past(run) && $past(at_end))
    else $error("idle timer expired early");

endmodule // rpscc_idle_tmr

// file: verilog/rpscc_lvl_filt.sv
// Debounce filter for one sensed pin level.
// Assumes the level code is synchronous to pclk.
`timescale 1ns/1ns
module rpscc_lvl_filt
  import rpscc_pkg::*;
#(
  parameter int SETTLE_CYC = SETTLE_CYC_DEF,
  parameter logic [1:0] RST_LVL = LVL_OPEN
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] raw,
  output logic [1:0] lvl_r
);

  logic [1:0] cand_r;
  logic [CNT_W-1:0] cnt_r;
  wire logic stable = (raw == cand_r);
  wire logic done = (cnt_r == CNT_W'(SETTLE_CYC - 1));

  // Level is taken once it has held for the settle time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cand_r <= RST_LVL;
      cnt_r <= '0;
      lvl_r <= RST_LVL;
    end else if (!stable) begin
      cand_r <= raw;
      cnt_r <= '0;
    end else if (done) begin
      lvl_r <= cand_r;
    end else begin
      cnt_r <= cnt_r + CNT_W'(1);
    end
  end

  settle_guard_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (lvl_r != $past(lvl_r)) |-> $past(done) && $past(stable))
    else $error("level taken before settle time");

endmodule // rpscc_lvl_filt

// file: verilog/rpscc_pkg.sv
// Package for the port-select and conditioning controller of a redriver.
// Assumes a 20 MHz pclk; level codes arrive from ternary pin sensors.
package rpscc_pkg;

  // Clock and timing
  localparam int CLK_HZ = 20_000_000;
  localparam int T_RCFG_US = 3000; // Longest reconfiguration time, us
  localparam int RCFG_CYC = T_RCFG_US * (CLK_HZ / 1_000_000);
  localparam int SETTLE_US = 1000; // Pin debounce time, us
  localparam int SETTLE_CYC_DEF = SETTLE_US * (CLK_HZ / 1_000_000);
  localparam int T_IDLE_MS = 300; // Typical idle wait, ms
  localparam int T_IDLE_MAX_MS = 400; // Longest idle wait, ms
  localparam int IDLE_CYC_DEF = T_IDLE_MS * (CLK_HZ / 1000);
  localparam int CNT_W = 24;

  // Sensed pin levels
  localparam logic [1:0] LVL_LOW = 2'h0;
  localparam logic [1:0] LVL_OPEN = 2'h1;
  localparam logic [1:0] LVL_HIGH = 2'h2;

  // Launch emphasis codes
  localparam logic [2:0] DE_0DB = 3'h0;
  localparam logic [2:0] DE_M3P5 = 3'h1;
  localparam logic [2:0] DE_M3P9 = 3'h2;
  localparam logic [2:0] DE_M5P1 = 3'h3;
  localparam logic [2:0] DE_M5P3 = 3'h4;
  // Output swing codes
  localparam logic OS_900 = 1'h0;
  localparam logic OS_1100 = 1'h1;
  // Receive boost codes
  localparam logic [1:0] EQ_0DB = 2'h0;
  localparam logic [1:0] EQ_3DB = 2'h1;
  localparam logic [1:0] EQ_6DB = 2'h2;
  localparam logic [1:0] EQ_9DB = 2'h3;

  // Register map, byte addresses
  localparam int AW = 12;
  localparam logic [AW-1:0] A_CTRL = 12'h000;
  localparam logic [AW-1:0] A_STAT = 12'h004;
  localparam logic [AW-1:0] A_HCFG = 12'h008;
  localparam logic [AW-1:0] A_CCFG = 12'h00C;
  localparam logic [AW-1:0] A_EVT = 12'h010;
  localparam int CTRL_REDET = 0;
  localparam int EVT_W = 2;
  localparam logic [EVT_W-1:0] EVT_RST = 2'h0;

  typedef enum logic {ST_SAVE, ST_ACTIVE} rpscc_state_t;

  // Unknown sensor code reads as the floating level
  function automatic logic [1:0] rpscc_norm(input logic [1:0] l);
    return (l == LVL_LOW || l == LVL_HIGH) ? l : LVL_OPEN;
  endfunction

  // Host-bound settings {emphasis, swing, boost}
  function automatic logic [5:0] rpscc_host_cfg(input logic [1:0] a,
                                                input logic [1:0] b);
    case ({a, b})
      {LVL_LOW, LVL_LOW}: return {DE_M3P9, OS_1100, EQ_3DB};
      {LVL_LOW, LVL_OPEN}: return {DE_M3P5, OS_900, EQ_3DB};
      {LVL_LOW, LVL_HIGH}: return {DE_0DB, OS_1100, EQ_3DB};
      {LVL_OPEN, LVL_LOW}: return {DE_0DB, OS_900, EQ_3DB};
      {LVL_OPEN, LVL_OPEN}: return {DE_M3P9, OS_1100, EQ_0DB};
      {LVL_OPEN, LVL_HIGH}: return {DE_M3P5, OS_900, EQ_0DB};
      {LVL_HIGH, LVL_LOW}: return {DE_0DB, OS_1100, EQ_0DB};
      {LVL_HIGH, LVL_OPEN}: return {DE_0DB, OS_900, EQ_0DB};
      default: return {DE_M5P3, OS_1100, EQ_6DB};
    endcase
  endfunction

  // Connector-bound settings {emphasis, swing, boost}
  function automatic logic [5:0] rpscc_conn_cfg(input logic [1:0] a,
                                                input logic [1:0] b);
    case ({a, b})
      {LVL_LOW, LVL_LOW}: return {DE_M5P3, OS_1100, EQ_0DB};
      {LVL_LOW, LVL_OPEN}: return {DE_M3P9, OS_1100, EQ_0DB};
      {LVL_LOW, LVL_HIGH}: return {DE_M3P5, OS_900, EQ_0DB};
      {LVL_OPEN, LVL_LOW}: return {DE_M5P1, OS_900, EQ_0DB};
      {LVL_OPEN, LVL_OPEN}: return {DE_M3P9, OS_1100, EQ_6DB};
      {LVL_OPEN, LVL_HIGH}: return {DE_M3P5, OS_900, EQ_6DB};
      {LVL_HIGH, LVL_LOW}: return {DE_M5P3, OS_1100, EQ_6DB};
      {LVL_HIGH, LVL_OPEN}: return {DE_M5P1, OS_900, EQ_6DB};
      default: return {DE_M5P3, OS_1100, EQ_9DB};
    endcase
  endfunction

endpackage

// file: verilog/rpscc_top.sv
// Port-select, conditioning decode and power-state control of a
// two-port redriver switch, with an APB register slave.
// Assumes pin level codes and link sense inputs are synchronous to pclk.
`timescale 1ns/1ns

// Summary of operation
// - Select low: host pairs go to port 2, port 1 held high impedance.
// - Select high: host pairs go to port 1, port 2 held high impedance.
// - Host side, first pin low: decode emphasis, swing, boost per table.
// - Host side, first pin open: decode emphasis, swing, boost per table.
// - Host side, first pin high: decode emphasis, swing, boost per table.
// - Connector side, first pin low: decode settings per table.
// - Connector side, first pin open: decode settings per table.
// - Connector side, first pin high: decode settings per table.
// - Power state depends only on bus electrical sense, port select and the redetect command.
// - Active: carry data, termination indication on, no detection.
// - No link or idle link: power saving with detection circuits on.
// - Each configuration pin decodes as low, open or high.
// - Port select has two levels; open counts as low.
// - Wait the idle interval before entering power saving.
// - New conditioning settings apply within 3 ms of a pin change.
module rpscc_top
  import rpscc_pkg::*;
#(
  parameter int SETTLE_CYC = SETTLE_CYC_DEF,
  parameter int IDLE_CYC = IDLE_CYC_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] port_sel_lvl,
  input wire logic [1:0] host_side_cfg_a,
  input wire logic [1:0] host_side_cfg_b,
  input wire logic [1:0] conn_side_cfg_a,
  input wire logic [1:0] conn_side_cfg_b,
  input wire logic far_term_present,
  input wire logic rx_activity,
  output logic port1_pairs_en,
  output logic port2_pairs_en,
  output logic port1_hiz,
  output logic port2_hiz,
  output logic term_ind,
  output logic term_detect_en,
  output logic squelch_en,
  output logic active_state,
  output logic [2:0] host_launch_emphasis_level,
  output logic host_output_swing,
  output logic [1:0] host_receive_boost,
  output logic [2:0] conn_launch_emphasis_level,
  output logic conn_output_swing,
  output logic [1:0] conn_receive_boost
);

  logic [1:0] sel_lvl;
  logic [1:0] ha_lvl;
  logic [1:0] hb_lvl;
  logic [1:0] ca_lvl;
  logic [1:0] cb_lvl;
  logic sel_r;
  rpscc_state_t state_r;
  rpscc_state_t state_nxt;
  logic idle_exp;
  logic [EVT_W-1:0] evt_r;
  logic [EVT_W-1:0] evt_nxt;
  logic [5:0] host_set_r;
  logic [5:0] conn_set_r;

  // Debounced pin levels; the select pin rests low
  rpscc_lvl_filt #(.SETTLE_CYC(SETTLE_CYC), .RST_LVL(LVL_LOW)) u_sel (
    .pclk(pclk), .presetn(presetn), .raw(port_sel_lvl), .lvl_r(sel_lvl)
  );
  rpscc_lvl_filt #(.SETTLE_CYC(SETTLE_CYC), .RST_LVL(LVL_OPEN)) u_ha (
    .pclk(pclk), .presetn(presetn), .raw(rpscc_norm(host_side_cfg_a)),
    .lvl_r(ha_lvl)
  );
  rpscc_lvl_filt #(.SETTLE_CYC(SETTLE_CYC), .RST_LVL(LVL_OPEN)) u_hb (
    .pclk(pclk), .presetn(presetn), .raw(rpscc_norm(host_side_cfg_b)),
    .lvl_r(hb_lvl)
  );
  rpscc_lvl_filt #(.SETTLE_CYC(SETTLE_CYC), .RST_LVL(LVL_OPEN)) u_ca (
    .pclk(pclk), .presetn(presetn), .raw(rpscc_norm(conn_side_cfg_a)),
    .lvl_r(ca_lvl)
  );
  rpscc_lvl_filt #(.SETTLE_CYC(SETTLE_CYC), .RST_LVL(LVL_OPEN)) u_cb (
    .pclk(pclk), .presetn(presetn), .raw(rpscc_norm(conn_side_cfg_b)),
    .lvl_r(cb_lvl)
  );

  // Select decode: only a sensed high picks port 1
  wire logic sel_bit = (sel_lvl == LVL_HIGH);
  wire logic sel_chg = (sel_bit != sel_r);

  // Conditioning decode from the settled ternary levels
  wire logic [5:0] host_set_nxt = rpscc_host_cfg(ha_lvl, hb_lvl);
  wire logic [5:0] conn_set_nxt = rpscc_conn_cfg(ca_lvl, cb_lvl);

  // APB decode
  wire logic apb_acc = psel & penable & ~pready;
  wire logic apb_wr = psel & penable & pready & pwrite; // Lands with answer
  wire logic apb_rd = apb_acc & ~pwrite;
  wire logic hit_ctrl = (paddr == A_CTRL);
  wire logic hit_stat = (paddr == A_STAT);
  wire logic hit_hcfg = (paddr == A_HCFG);
  wire logic hit_ccfg = (paddr == A_CCFG);
  wire logic hit_evt = (paddr == A_EVT);
  wire logic hit_any = hit_ctrl | hit_stat | hit_hcfg | hit_ccfg | hit_evt;
  wire logic redetect = apb_wr & hit_ctrl & pwdata[CTRL_REDET];
  wire logic [EVT_W-1:0] evt_clr =
    (apb_wr & hit_evt) ? pwdata[EVT_W-1:0] : '0;

  // Read data mux; status shows the block's live state
  wire logic [31:0] rd_mux =
    hit_stat ? {28'h0000000, far_term_present, rx_activity, sel_r,
                state_r == ST_ACTIVE} :
    hit_hcfg ? {26'h0, host_set_r} :
    hit_ccfg ? {26'h0, conn_set_r} :
    hit_evt ? {30'h0, evt_r} :
    32'h00000000;

  // Idle covers no connection and an electrically idle link
  wire logic idle_run =
    (state_r == ST_ACTIVE) & ~(far_term_present & rx_activity);

  rpscc_idle_tmr #(.IDLE_CYC(IDLE_CYC)) u_idle (
    .pclk(pclk), .presetn(presetn), .run(idle_run), .expired_r(idle_exp)
  );

  // Power state choice from bus sense, select and the redetect command only
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_SAVE: begin
        if (!sel_chg && !redetect && far_term_present && rx_activity) begin
          state_nxt = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (sel_chg || redetect || idle_exp) begin
          state_nxt = ST_SAVE;
        end
      end
      default: state_nxt = ST_SAVE;
    endcase
  end

  // Sticky events: bit0 entered saving, bit1 entered active; set wins
  wire logic [EVT_W-1:0] evt_set = {
    (state_r == ST_SAVE) && (state_nxt == ST_ACTIVE),
    (state_r == ST_ACTIVE) && (state_nxt == ST_SAVE)};
  assign evt_nxt = (evt_r & ~evt_clr) | evt_set;

  // State, select and event registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_SAVE;
      sel_r <= 1'b0;
      evt_r <= EVT_RST;
    end else begin
      state_r <= state_nxt;
      sel_r <= sel_bit;
      evt_r <= evt_nxt;
    end
  end

  // Port routing; the unselected port stays high impedance
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port1_pairs_en <= 1'b0;
      port2_pairs_en <= 1'b1;
      port1_hiz <= 1'b1;
      port2_hiz <= 1'b0;
    end else begin
      port1_pairs_en <= sel_bit;
      port1_hiz <= ~sel_bit;
      port2_pairs_en <= ~sel_bit;
      port2_hiz <= sel_bit;
    end
  end

  // Termination and detection controls per power state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      term_ind <= 1'b0;
      term_detect_en <= 1'b1;
      squelch_en <= 1'b1;
      active_state <= 1'b0;
    end else if (state_nxt == ST_ACTIVE) begin
      term_ind <= 1'b1;
      term_detect_en <= 1'b0;
      squelch_en <= 1'b0;
      active_state <= 1'b1;
    end else begin
      term_ind <= far_term_present;
      term_detect_en <= 1'b1;
      squelch_en <= 1'b1;
      active_state <= 1'b0;
    end
  end

  // Conditioning outputs follow the settled pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_set_r <= {DE_M3P9, OS_1100, EQ_0DB};
      conn_set_r <= {DE_M3P9, OS_1100, EQ_6DB};
    end else begin
      host_set_r <= host_set_nxt;
      conn_set_r <= conn_set_nxt;
    end
  end

  assign host_launch_emphasis_level = host_set_r[5:3];
  assign host_output_swing = host_set_r[2];
  assign host_receive_boost = host_set_r[1:0];
  assign conn_launch_emphasis_level = conn_set_r[5:3];
  assign conn_output_swing = conn_set_r[2];
  assign conn_receive_boost = conn_set_r[1:0];

  // APB answer: one wait cycle, error on unmapped address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= apb_acc;
      pslverr <= apb_acc & ~hit_any;
      prdata <= apb_rd ? rd_mux : 32'h00000000;
    end
  end

  port_route_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !sel_r |-> port2_pairs_en && port1_hiz && !port1_pairs_en)
    else $error("select low did not route to port 2");

  port_one_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    sel_r |-> port1_pairs_en && port2_hiz && !port2_pairs_en)
    else $error("select high did not route to port 1");

  host_decode_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ha_lvl == LVL_LOW && hb_lvl == LVL_OPEN) |=>
      host_launch_emphasis_level == DE_M3P5 && host_output_swing == OS_900
      && host_receive_boost == EQ_3DB)
    else $error("host low-open decode wrong");

  host_high_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ha_lvl == LVL_HIGH && hb_lvl == LVL_HIGH) |=>
      host_launch_emphasis_level == DE_M5P3 && host_receive_boost == EQ_6DB)
    else $error("host high-high decode wrong");

  conn_decode_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ca_lvl == LVL_OPEN && cb_lvl == LVL_LOW) |=>
      conn_launch_emphasis_level == DE_M5P1 && conn_output_swing == OS_900
      && conn_receive_boost == EQ_0DB)
    else $error("connector open-low decode wrong");

  conn_high_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ca_lvl == LVL_HIGH && cb_lvl == LVL_HIGH) |=>
      conn_receive_boost == EQ_9DB && conn_output_swing == OS_1100)
    else $error("connector high-high decode wrong");

  active_term_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state_r == ST_ACTIVE) |-> term_ind && !term_detect_en && active_state)
    else $error("active state termination controls wrong");

  save_entry_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    $fell(active_state) |-> $past(idle_exp) || $past(sel_chg)
      || $past(redetect))
    else $error("power saving entered without cause");

  save_detect_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state_r == ST_SAVE) |-> term_detect_en && squelch_en)
    else $error("detection off while power saving");

  apb_answer_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && penable && !pready) |=> pready ##1 !pready)
    else $error("apb answer not a single cycle pulse");

  host_low_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ha_lvl == LVL_LOW && hb_lvl == LVL_LOW) |=>
      host_launch_emphasis_level == DE_M3P9 && host_output_swing == OS_1100
      && host_receive_boost == EQ_3DB)
    else $error("host low-low decode wrong");

  host_open_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ha_lvl == LVL_OPEN && hb_lvl == LVL_LOW) |=>
      host_launch_emphasis_level == DE_0DB && host_output_swing == OS_900
      && host_receive_boost == EQ_3DB)
    else $error("host open-low decode wrong");

  conn_low_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ca_lvl == LVL_LOW && cb_lvl == LVL_LOW) |=>
      conn_launch_emphasis_level == DE_M5P3 && conn_output_swing == OS_1100
      && conn_receive_boost == EQ_0DB)
    else $error("connector low-low decode wrong");

  sel_open_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (sel_lvl != LVL_HIGH) |=> !port1_pairs_en && port2_pairs_en)
    else $error("select not high still picked port 1");

  redet_exit_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state_r == ST_ACTIVE && redetect) |=> !active_state)
    else $error("redetect did not leave active state");

  save_hold_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state_r == ST_SAVE && !(far_term_present && rx_activity)) |=>
      !active_state)
    else $error("left power saving without bus activity");

  evt_sticky_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (evt_set != '0) |=> ($past(evt_set) & ~evt_r) == '0)
    else $error("state change event lost");

  slv_err_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (apb_acc && !hit_any) |=> pslverr && pready)
    else $error("unmapped access without error");

  rd_idle_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !pready |-> prdata == 32'h00000000)
    else $error("read data outside answer cycle");

endmodule // rpscc_top
